// ==== rtl/fah_pkg.sv ====
// How it works
// - summary bit ORs its group's level-two bits
// - level-two bit ORs its level-three bits
// - detected fault latches until group clear
// - clear works only once condition gone
// - hide bit keeps latching, blocks summary
// - hidden faults never pull fault pin
// - pin driver on: unhidden fault pulls low
// - pin driver off: summary set, pin released
// - active: embedded frame fault sets tone flag
// - sleep: heartbeat only if enabled, no fault tones
// - sleep: tone detection only with receive enable
// - tones follow config register direction bit
// - comm tone single burst, heartbeat periodic
// - shutdown sniff hit enters validate, confirms, wakes
// - sleep/validate wake faults raise wake, ignore hides
// - active: only force command raises wake
// - host wake stays latched until reset
// - disable field all ones blocks every trigger
// - wake sets fault; disarm, clear, rearm
// - wake level status follows sensed pin
// - wake pin high impedance when not pulled
// - sniff fires after run, idle gap resets
// - sniff runs only in shutdown
package fah_pkg;
  localparam int CLK_KHZ = 20000;
  localparam int CLK_MHZ = 20;
  localparam int N_GRP   = 4;
  localparam int L2_PER  = 2;
  localparam int L3_PER  = 2;
  localparam int N_L2    = N_GRP * L2_PER;
  localparam int N_L3    = N_L2 * L3_PER;
  // register offsets
  localparam logic [7:0] A_CONFIG = 8'h00;
  localparam logic [7:0] A_WDIS   = 8'h01;
  localparam logic [7:0] A_HIDE   = 8'h02;
  localparam logic [7:0] A_CLEAR  = 8'h03;
  localparam logic [7:0] A_CMD    = 8'h04;
  localparam logic [7:0] A_SUMM   = 8'h05;
  localparam logic [7:0] A_LVL2   = 8'h06;
  localparam logic [7:0] A_LVL3LO = 8'h07;
  localparam logic [7:0] A_LVL3HI = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h09;
  localparam logic [7:0] A_MODE   = 8'h0A;
  // config fields and reset value
  localparam int CFG_HB_SEND   = 0;
  localparam int CFG_DIR       = 1;
  localparam int CFG_FPIN      = 2;
  localparam int CFG_TONE_RX   = 5;
  localparam int CFG_SNIFF_DIS = 6;
  localparam int CFG_SNIFF_EN  = 7;
  localparam logic [7:0] CFG_RESET = 8'h04;
  localparam int CMD_WAKE_FORCE = 0;
  localparam int CMD_SEND_COMM  = 1;
  localparam logic [1:0] WAKE_DIS_ALL = 2'h3;
  // fault groups
  localparam int GRP_SYS  = 1;
  localparam int FTONE_L3 = 15;
  // tones
  localparam logic TONE_COMM = 1'b0;
  localparam logic TONE_HB   = 1'b1;
  localparam logic [9:0] HB_COUPLETS   = 10'h01E;
  localparam logic [9:0] COMM_COUPLETS = 10'h05A;
  // timing
  localparam int HB_PERIOD_MS  = 400;
  localparam int HB_PERIOD_CYC = HB_PERIOD_MS * CLK_KHZ;
  localparam int VALIDATE_MS   = 10;
  localparam int VALIDATE_CYC  = VALIDATE_MS * CLK_KHZ;
  localparam int SNIFF_IDLE_US  = 50;
  localparam int SNIFF_IDLE_CYC = SNIFF_IDLE_US * CLK_MHZ;
  localparam int SNIFF_COUNT    = 48;
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    MODE_ACTIVE   = 2'b00,
    MODE_SLEEP    = 2'b01,
    MODE_SHUTDOWN = 2'b10,
    MODE_VALIDATE = 2'b11
  } fah_mode_t;

  typedef struct packed {
    logic       send;
    logic       kind;
    logic       dir;
    logic [9:0] couplets;
  } fah_tone_t;

  typedef struct packed {
    logic heartbeat_missing;
    logic heartbeat_too_fast;
    logic always_on_switch_fail;
    logic factory_check_error;
    logic config_monitor_error;
  } fah_wake_src_t;
endpackage

// ==== rtl/fah_sniff.sv ====
`timescale 1ns/10ps
module fah_sniff
  import fah_pkg::*;
#(
  parameter int IDLE_CYC = SNIFF_IDLE_CYC,
  parameter int RUN_N    = SNIFF_COUNT
)(
  input  wire logic i_clk_sys, // system clock
  input  wire logic i_rstn,    // sync reset, low
  input  wire logic i_en,      // detector armed
  input  wire logic i_couplet, // one qualifying couplet
  output logic      o_fire     // run complete pulse
);
  logic [15:0]      run_q;
  logic [CNT_W-1:0] idle_q;

  // count couplets, drop the run on idle gap or disarm
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn || !i_en)
    begin
      run_q  <= 16'h0000;
      idle_q <= '0;
      o_fire <= 1'b0;
    end
    else if (i_couplet)
    begin
      idle_q <= '0;
      o_fire <= (run_q == 16'(RUN_N - 1));
      run_q  <= (run_q == 16'(RUN_N - 1)) ? 16'h0000 : run_q + 16'h0001;
    end
    else
    begin
      o_fire <= 1'b0;
      if (idle_q >= CNT_W'(IDLE_CYC))
        run_q <= 16'h0000;
      else
        idle_q <= idle_q + 1'b1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  a_sniff_fire_run: assert property (
    o_fire |-> $past(i_couplet) && $past(run_q) == 16'(RUN_N - 1))
    else $error("sniff fired without full run");
  a_sniff_disarmed: assert property (
    !i_en |=> run_q == 16'h0000 && !o_fire)
    else $error("sniff counted while disarmed");
endmodule // fah_sniff

// ==== rtl/fah_top.sv ====
`timescale 1ns/10ps
module fah_top
  import fah_pkg::*;
#(
  parameter int HB_CYC   = HB_PERIOD_CYC,
  parameter int VAL_CYC  = VALIDATE_CYC,
  parameter int IDLE_CYC = SNIFF_IDLE_CYC,
  parameter int SNIFF_N  = SNIFF_COUNT
)(
  input  wire logic            i_clk_sys,        // system clock
  input  wire logic            i_rstn,           // sync reset, low
  input  wire logic [7:0]      i_addr,           // register address
  input  wire logic [7:0]      i_wdata,          // write data
  input  wire logic            i_wr,             // write strobe
  input  wire logic            i_rd,             // read strobe
  output logic      [7:0]      o_rdata,          // read data, next cycle
  input  wire logic [N_L3-1:0] i_fault_raw,      // level-three conditions
  input  wire logic            i_embed_fault,    // frame fault criterion
  input  wire fah_wake_src_t   i_wake_src,       // wake fault levels
  input  wire logic            i_couplet,        // sniffer couplet pin
  input  wire logic            i_tone_fault,     // tone receiver fault pin
  input  wire logic            i_wake_sense,     // wake pin comparator
  output logic                 o_fault_out_n_o,  // fault pin level
  output logic                 o_fault_out_n_oe, // fault pin pull low
  output logic                 o_host_wake_o,    // wake pin level
  output logic                 o_host_wake_oe,   // wake pull-up on
  output fah_tone_t            o_tone,           // tone request
  output fah_mode_t            o_mode            // power mode
);
  localparam int SY_COUP = 0;
  localparam int SY_TONE = 1;
  localparam int SY_WAKE = 2;

  logic [2:0]       s1_q, s2_q, s3_q, stb_q, stp_q, edge_w;
  logic [7:0]       cfg_q;
  logic [1:0]       wdis_q;
  logic [N_GRP-1:0] hide_q, summ_q, clr_p, grp_or;
  logic [N_L3-1:0]  l3_q, raw_all, clr_l3;
  logic [N_L2-1:0]  l2;
  fah_mode_t        mode_q;
  logic             hw_q, hwf_q, fo_oe_q, hw_oe_q;
  logic             force_p, comm_p, dis_all, ftone_evt, trig, sniff_fire;
  logic             sniff_en, rx_live;
  logic [CNT_W-1:0] val_q, hb_q;
  fah_tone_t        tone_q;
  logic [7:0]       rdata_q;

  function automatic int grp_of(input int idx);
    return idx / (L2_PER * L3_PER);
  endfunction

  function automatic logic hit(input logic [7:0] off);
    return i_addr == off;
  endfunction

  // pin inputs through three flops, level taken when last two agree
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      s1_q  <= 3'h0;
      s2_q  <= 3'h0;
      s3_q  <= 3'h0;
      stb_q <= 3'h0;
      stp_q <= 3'h0;
    end
    else
    begin
      s1_q  <= {i_wake_sense, i_tone_fault, i_couplet};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      stb_q <= (s2_q & s3_q) | (stb_q & (s2_q | s3_q));
      stp_q <= stb_q;
    end
  end
  assign edge_w = stb_q & ~stp_q;

  // write side effects that last one cycle
  assign clr_p   = (i_wr && hit(A_CLEAR)) ? i_wdata[N_GRP-1:0] : '0;
  assign force_p = i_wr && hit(A_CMD) && i_wdata[CMD_WAKE_FORCE];
  assign comm_p  = i_wr && hit(A_CMD) && i_wdata[CMD_SEND_COMM];
  assign dis_all = (wdis_q == WAKE_DIS_ALL);

  // software-written configuration
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      cfg_q  <= CFG_RESET;
      wdis_q <= 2'h0;
      hide_q <= '0;
    end
    else if (i_wr)
    begin
      if (hit(A_CONFIG))
        cfg_q <= i_wdata;
      else if (hit(A_WDIS))
        wdis_q <= i_wdata[1:0];
      else if (hit(A_HIDE))
        hide_q <= i_wdata[N_GRP-1:0];
    end
  end

  // tone receiver live in validate, or in sleep when enabled
  assign rx_live = (mode_q == MODE_VALIDATE) ||
                   (mode_q == MODE_SLEEP && cfg_q[CFG_TONE_RX]);

  // fault tone flag sources per power mode
  assign ftone_evt = (mode_q == MODE_ACTIVE && i_embed_fault) ||
                     (rx_live && edge_w[SY_TONE]);

  // hierarchy: level three feeds level two feeds group summary
  always_comb
  begin
    raw_all = i_fault_raw;
    raw_all[FTONE_L3] = i_fault_raw[FTONE_L3] | ftone_evt;
    for (int i = 0; i < N_L3; i++)
      clr_l3[i] = clr_p[grp_of(i)];
    for (int j = 0; j < N_L2; j++)
      l2[j] = |l3_q[j*L3_PER +: L3_PER];
    for (int g = 0; g < N_GRP; g++)
      grp_or[g] = |l2[g*L2_PER +: L2_PER];
    grp_or[GRP_SYS] = grp_or[GRP_SYS] | hwf_q;
  end

  // latch faults; a live condition beats its group clear
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      l3_q <= '0;
    else
      l3_q <= raw_all | (l3_q & ~clr_l3);
  end

  // summary hides masked groups, bits below still latch
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      summ_q <= '0;
    else
      summ_q <= grp_or & ~hide_q;
  end

  // open-drain fault pin pulled low on any visible summary while the config pin driver bit is set
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      fo_oe_q         <= 1'b0;
      o_fault_out_n_o <= 1'b0;
    end
    else
    begin
      fo_oe_q         <= cfg_q[CFG_FPIN] && (|summ_q);
      o_fault_out_n_o <= 1'b0;
    end
  end

  // wake trigger paths, all blocked by the disable field
  assign trig = !dis_all && (
    ((mode_q == MODE_SLEEP || mode_q == MODE_VALIDATE) &&
     (ftone_evt || (|i_wake_src))) ||
    (mode_q == MODE_ACTIVE && force_p));

  // wake latch cleared only by reset; fault bit has its own clear
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      hw_q    <= 1'b0;
      hwf_q   <= 1'b0;
      hw_oe_q <= 1'b0;
    end
    else
    begin
      hw_q    <= hw_q | trig;
      hwf_q   <= (trig && !hw_q) || (hwf_q && !(dis_all && clr_p[GRP_SYS]));
      hw_oe_q <= hw_q;
    end
  end

  // power mode: software selects, sniff and validate move on their own
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      mode_q <= MODE_ACTIVE;
      val_q  <= '0;
    end
    else
    begin
      case (mode_q)
        MODE_SHUTDOWN:
        begin
          val_q <= '0;
          if (sniff_fire)
            mode_q <= MODE_VALIDATE;
          else if (i_wr && hit(A_MODE) && i_wdata[1:0] != MODE_VALIDATE)
            mode_q <= fah_mode_t'(i_wdata[1:0]);
        end
        MODE_VALIDATE:
        begin
          val_q <= val_q + 1'b1;
          if (edge_w[SY_TONE] || val_q == CNT_W'(VAL_CYC - 1))
            mode_q <= MODE_SHUTDOWN;
        end
        default:
        begin
          val_q <= '0;
          if (i_wr && hit(A_MODE) && i_wdata[1:0] != MODE_VALIDATE)
            mode_q <= fah_mode_t'(i_wdata[1:0]);
        end
      endcase
    end
  end

  // sniff detector armed only in shutdown with enable and no disable
  assign sniff_en = (mode_q == MODE_SHUTDOWN) && cfg_q[CFG_SNIFF_EN] &&
                    !cfg_q[CFG_SNIFF_DIS];

  fah_sniff #(
    .IDLE_CYC (IDLE_CYC),
    .RUN_N    (SNIFF_N)
  ) u_sniff (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_en      (sniff_en),
    .i_couplet (edge_w[SY_COUP]),
    .o_fire    (sniff_fire)
  );

  // heartbeat period timer, runs only while sending in sleep
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn || mode_q != MODE_SLEEP || !cfg_q[CFG_HB_SEND])
      hb_q <= '0;
    else if (hb_q == CNT_W'(HB_CYC - 1))
      hb_q <= '0;
    else
      hb_q <= hb_q + 1'b1;
  end

  // tone requests: periodic heartbeat bursts, single comm burst
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      tone_q <= '0;
    else
    begin
      tone_q     <= '0;
      tone_q.dir <= cfg_q[CFG_DIR];
      if (mode_q == MODE_SLEEP && cfg_q[CFG_HB_SEND] &&
          hb_q == CNT_W'(HB_CYC - 1))
      begin
        tone_q.send     <= 1'b1;
        tone_q.kind     <= TONE_HB;
        tone_q.couplets <= HB_COUPLETS;
      end
      else if (comm_p)
      begin
        tone_q.send     <= 1'b1;
        tone_q.kind     <= TONE_COMM;
        tone_q.couplets <= COMM_COUPLETS;
      end
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn || !i_rd)
      rdata_q <= 8'h00;
    else if (hit(A_CONFIG))
      rdata_q <= cfg_q;
    else if (hit(A_WDIS))
      rdata_q <= {6'h00, wdis_q};
    else if (hit(A_HIDE))
      rdata_q <= {4'h0, hide_q};
    else if (hit(A_SUMM))
      rdata_q <= {4'h0, summ_q};
    else if (hit(A_LVL2))
      rdata_q <= l2;
    else if (hit(A_LVL3LO))
      rdata_q <= l3_q[7:0];
    else if (hit(A_LVL3HI))
      rdata_q <= l3_q[15:8];
    else if (hit(A_STATUS))
      rdata_q <= {2'h0, mode_q, hwf_q, l3_q[FTONE_L3], stb_q[SY_WAKE], hw_q};
    else if (hit(A_MODE))
      rdata_q <= {6'h00, mode_q};
    else
      rdata_q <= 8'h00;
  end

  assign o_rdata          = rdata_q;
  assign o_fault_out_n_oe = fo_oe_q;
  assign o_host_wake_o    = hw_oe_q;
  assign o_host_wake_oe   = hw_oe_q;
  assign o_tone           = tone_q;
  assign o_mode           = mode_q;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  sequence s_sniff_hit;
    mode_q == MODE_SHUTDOWN ##0 sniff_fire;
  endsequence
  sequence s_valid_tone;
    mode_q == MODE_VALIDATE ##0 edge_w[SY_TONE] && !dis_all;
  endsequence

  a_hide_blocks_summ: assert property (
    hide_q[0] && $stable(hide_q) |=> !summ_q[0])
    else $error("hidden group reached summary");
  a_summ_follows_l3: assert property (
    l3_q[0] && !hide_q[0] |=> summ_q[0])
    else $error("level three fault missing from summary");
  a_fault_pin_low: assert property (
    cfg_q[CFG_FPIN] && summ_q != '0 |=> o_fault_out_n_oe)
    else $error("fault pin not pulled");
  a_pin_off_free: assert property (
    !cfg_q[CFG_FPIN] |=> !o_fault_out_n_oe)
    else $error("fault pin pulled while driver off");
  a_pin_release: assert property (
    summ_q == '0 |=> !o_fault_out_n_oe)
    else $error("fault pin held with empty summary");
  a_latch_holds: assert property (
    l3_q[2] && clr_p[0] == 1'b0 |=> l3_q[2])
    else $error("fault bit dropped without clear");
  a_clear_live: assert property (
    i_fault_raw[0] && clr_p[0] |=> l3_q[0])
    else $error("live fault was cleared");
  a_active_force: assert property (
    mode_q == MODE_ACTIVE && !force_p && !hw_q |=> !hw_q)
    else $error("wake raised in active without force");
  a_wake_latched: assert property (
    hw_q |=> hw_q)
    else $error("wake latch dropped");
  a_wake_disabled: assert property (
    dis_all && !hw_q |=> !hw_q)
    else $error("wake raised while disabled");
  a_wake_hiz: assert property (
    !hw_q |=> !o_host_wake_oe)
    else $error("wake pin driven while idle");
  a_sniff_validate: assert property (
    s_sniff_hit |=> mode_q == MODE_VALIDATE)
    else $error("sniff hit did not enter validate");
  a_validate_wake: assert property (
    s_valid_tone |=> hw_q ##1 o_host_wake_oe)
    else $error("confirmed tone did not wake host");
  a_hb_sleep_only: assert property (
    tone_q.send && tone_q.kind == TONE_HB |-> $past(mode_q) == MODE_SLEEP)
    else $error("heartbeat sent outside sleep");
endmodule // fah_top

// ==== verif/fah_far_model.sv ====
`timescale 1ns/10ps
module fah_far_model (
  input  wire logic i_clk_sys,   // system clock
  input  wire logic i_fault_oe,  // fault pin pull low
  input  wire logic i_wake_o,    // wake pin level
  input  wire logic i_wake_oe,   // wake pull-up on
  output logic      o_fault_pin, // resolved fault pin
  output logic      o_embed,     // frame fault flag
  output logic      o_couplet,   // sniffer couplet line
  output logic      o_tone,      // tone receiver line
  output logic      o_sense      // wake comparator
);
  // pull-up on fault pin, pull-down on wake pin
  assign o_fault_pin = i_fault_oe ? 1'b0 : 1'b1;
  assign o_sense     = i_wake_oe ? i_wake_o : 1'b0;
  // lines idle low
  initial
  begin
    o_embed   = 1'b0;
    o_couplet = 1'b0;
    o_tone    = 1'b0;
  end
  // response frame of a stack read, fault embedded or not
  task automatic stack_read(input logic flt);
    begin
      @(posedge i_clk_sys) o_embed <= flt;
      @(posedge i_clk_sys) o_embed <= 1'b0;
    end
  endtask
  // couplet run with a gap after each
  task automatic couplets(input int n, input int gap);
    int k;
    begin
      for (k = 0; k < n; k++)
      begin
        @(posedge i_clk_sys) o_couplet <= 1'b1;
        // hold two cycles so the second and third filter flops agree
        repeat (2) @(posedge i_clk_sys);
        o_couplet <= 1'b0;
        repeat (gap) @(posedge i_clk_sys);
      end
    end
  endtask
  // one fault tone seen by the receiver
  task automatic tone_edge;
    begin
      @(posedge i_clk_sys) o_tone <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      o_tone <= 1'b0;
    end
  endtask
endmodule // fah_far_model

// ==== verif/fah_top_bench.sv ====
`timescale 1ns/10ps
module fah_top_bench;
  import fah_pkg::*;
  logic          clk, rstn, wr, rd, fpin, emb, cpl, ton, sns, got;
  logic [7:0]    addr, wdata, rdata;
  logic [15:0]   raw;
  fah_wake_src_t wsrc;
  logic          w_o, w_oe, f_oe, f_o;
  fah_tone_t     tone, tcap;
  fah_mode_t     mode;
  int            mismatches, tests_run;
  // device under test with shortened counts
  fah_top #(.HB_CYC(50), .VAL_CYC(40), .IDLE_CYC(20), .SNIFF_N(4)) i_fah_top (
    .i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_fault_raw(raw), .i_embed_fault(emb),
    .i_wake_src(wsrc), .i_couplet(cpl), .i_tone_fault(ton), .i_wake_sense(sns),
    .o_fault_out_n_o(f_o), .o_fault_out_n_oe(f_oe), .o_host_wake_o(w_o),
    .o_host_wake_oe(w_oe), .o_tone(tone), .o_mode(mode));
  fah_far_model i_fah_far_model (
    .i_clk_sys(clk), .i_fault_oe(f_oe), .i_wake_o(w_o), .i_wake_oe(w_oe),
    .o_fault_pin(fpin), .o_embed(emb), .o_couplet(cpl), .o_tone(ton), .o_sense(sns));
  // clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        mismatches++;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    begin
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk) wr <= 1'b0;
    end
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    begin
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdata});
    end
  endtask
  task automatic wait_tone(input int lim);
    int k;
    begin
      got = 1'b0;
      for (k = 0; k < lim && !got; k++)
      begin
        @(negedge clk);
        if (tone.send === 1'b1)
        begin
          got  = 1'b1;
          tcap = tone;
        end
      end
    end
  endtask
  task automatic pulse_raw(input int b);
    begin
      @(posedge clk) raw[b] <= 1'b1;
      @(posedge clk) raw[b] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic do_reset;
    begin
      rstn <= 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
    end
  endtask
  task automatic report_and_stop;
    begin
      if (mismatches == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // watchdog
  initial
  begin
    #(50 * 20000);
    mismatches++;
    report_and_stop;
  end
  // main sequence
  initial
  begin
    mismatches = 0;
    tests_run  = 0;
    {rstn, wr, rd, addr, wdata, raw, wsrc} = '0;
    do_reset;
    // reset state, unmapped read, wake pin released
    rreg(A_CONFIG, CFG_RESET);
    rreg(A_STATUS, 8'h00);
    rreg(8'h0F, 8'h00);
    chk("wake oe", 16'h0000, {15'h0000, w_oe});
    // latch and hierarchy
    pulse_raw(0);
    rreg(A_LVL3LO, 8'h01);
    rreg(A_LVL2, 8'h01);
    rreg(A_SUMM, 8'h01);
    chk("fault pin", 16'h0000, {15'h0000, fpin});
    chk("fault level", 16'h0000, {15'h0000, f_o});
    @(posedge clk) raw[0] <= 1'b1;
    wreg(A_CLEAR, 8'h01);
    rreg(A_LVL3LO, 8'h01);
    @(posedge clk) raw[0] <= 1'b0;
    wreg(A_CLEAR, 8'h01);
    repeat (3) @(posedge clk);
    rreg(A_LVL3LO, 8'h00);
    rreg(A_SUMM, 8'h00);
    chk("fault pin", 16'h0001, {15'h0000, fpin});
    // hidden group latches but stays out of summary and pin
    wreg(A_HIDE, 8'h01);
    pulse_raw(1);
    rreg(A_LVL3LO, 8'h02);
    rreg(A_SUMM, 8'h00);
    chk("fault pin", 16'h0001, {15'h0000, fpin});
    wreg(A_CLEAR, 8'h01);
    wreg(A_HIDE, 8'h00);
    // pin driver off
    wreg(A_CONFIG, 8'h00);
    pulse_raw(4);
    rreg(A_SUMM, 8'h02);
    chk("fault pin", 16'h0001, {15'h0000, fpin});
    wreg(A_CLEAR, 8'h02);
    // active: wake sources ignored, frame fault detected
    wsrc <= '1;
    repeat (5) @(posedge clk);
    wsrc <= '0;
    rreg(A_STATUS, 8'h00);
    i_fah_far_model.stack_read(1'b1);
    repeat (4) @(posedge clk);
    rreg(A_STATUS, 8'h04);
    wreg(A_CLEAR, 8'h08);
    wreg(A_CMD, 8'h01);
    repeat (8) @(posedge clk);
    rreg(A_STATUS, 8'h0B);
    wreg(A_WDIS, {6'h00, WAKE_DIS_ALL});
    wreg(A_CLEAR, 8'h02);
    rreg(A_STATUS, 8'h03);
    chk("wake oe", 16'h0001, {15'h0000, w_oe});
    // single comm burst
    wreg(A_CMD, 8'h02);
    wait_tone(10);
    chk("comm tone", {3'b000, 3'b100, COMM_COUPLETS},
        {3'b000, got, tcap.kind, tcap.dir, tcap.couplets});
    // sleep section
    do_reset;
    wreg(A_CONFIG, 8'h03);
    wreg(A_MODE, 8'h01);
    wait_tone(60);
    chk("hb tone", {3'b000, 3'b111, HB_COUPLETS},
        {3'b000, got, tcap.kind, tcap.dir, tcap.couplets});
    // the burst repeats one period later
    wait_tone(60);
    chk("hb again", {3'b000, 3'b111, HB_COUPLETS},
        {3'b000, got, tcap.kind, tcap.dir, tcap.couplets});
    wreg(A_CONFIG, 8'h00);
    wait_tone(60);
    chk("hb off", 16'h0000, {15'h0000, got});
    i_fah_far_model.tone_edge;
    repeat (10) @(posedge clk);
    rreg(A_STATUS, 8'h10);
    wreg(A_WDIS, {6'h00, WAKE_DIS_ALL});
    wsrc.heartbeat_missing <= 1'b1;
    repeat (5) @(posedge clk);
    wsrc.heartbeat_missing <= 1'b0;
    rreg(A_STATUS, 8'h10);
    wreg(A_WDIS, 8'h00);
    wreg(A_HIDE, 8'h0F);
    wsrc.config_monitor_error <= 1'b1;
    repeat (5) @(posedge clk);
    wsrc.config_monitor_error <= 1'b0;
    repeat (4) @(posedge clk);
    rreg(A_STATUS, 8'h1B);
    wreg(A_CONFIG, 8'h20);
    i_fah_far_model.tone_edge;
    repeat (10) @(posedge clk);
    rreg(A_STATUS, 8'h1F);
    // shutdown section
    do_reset;
    wreg(A_CONFIG, 8'h80);
    i_fah_far_model.couplets(5, 3);
    repeat (8) @(posedge clk);
    rreg(A_MODE, 8'h00);
    wreg(A_MODE, 8'h02);
    i_fah_far_model.couplets(3, 3);
    repeat (30) @(posedge clk);
    i_fah_far_model.couplets(3, 3);
    repeat (10) @(posedge clk);
    rreg(A_MODE, 8'h02);
    i_fah_far_model.couplets(4, 3);
    repeat (6) @(posedge clk);
    rreg(A_MODE, 8'h03);
    chk("mode out", 16'h0003, {14'h0000, mode});
    i_fah_far_model.tone_edge;
    repeat (10) @(posedge clk);
    rreg(A_STATUS, 8'h2F);
    report_and_stop;
  end
endmodule // fah_top_bench
